// >>> dpssp_defs.vh
// constants for the dual protocol serial slave port
`ifndef DPSSP_DEFS_VH
`define DPSSP_DEFS_VH
`define DPSSP_I2C_ADDR_HI 6'h36
`define DPSSP_FIFO_DEPTH  16
`define DPSSP_FIFO_AW     4
`define DPSSP_ADDR_W      8
`define DPSSP_DATA_W      8
`define DPSSP_SPI_BIT_RW  4'h0
`define DPSSP_SPI_BIT_D0  4'h8
`define DPSSP_SPI_BIT_D7  4'hf
`define DPSSP_BYTE_BITS   4'h8
`define DPSSP_STRAP_WAIT  2'h2
`endif

// >>> dpssp_host.sv
// host master model driving the primary pins as i2c or spi master
`timescale 1ns/1ps
module dpssp_host (
  // clock and resolved line levels
  input  wire i_clk,
  input  wire i_sda_line,
  input  wire i_scl_line,
  input  wire i_sdo_line,
  // driven pins
  output reg  o_scl,
  output reg  o_sda_low,
  output reg  o_chip_select_n
);
  // idle: clock high, lines released, not selected
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_chip_select_n = 1'b1;
  end
  task automatic tick(input integer n);
    repeat (n) @(posedge i_clk);
  endtask
  // one bit: 5 low then 3 high, stretching honoured
  task automatic bit_io(input b, output r);
    integer k;
    begin
      tick(2);
      o_sda_low <= ~b;
      tick(3);
      o_scl <= 1'b1;
      tick(1);
      for (k = 0; k < 4000 && !i_scl_line; k = k + 1)
        tick(1);
      tick(1);
      r = i_sda_line;
      tick(1);
      o_scl <= 1'b0;
    end
  endtask
  // start (also repeated) or stop; data is set up with clock low, the condition edge comes with clock high
  task automatic i2c_cond(input start);
    begin
      tick(2);
      o_sda_low <= ~start;
      tick(3);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= start;
      tick(4);
      o_scl <= ~start;
    end
  endtask
  // whole byte msb first, then the acknowledge bit (line level)
  task automatic i2c_byte(input [7:0] d, input ack_in, output [7:0] q, output ack_n);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r);
        q[i] = r;
      end
      bit_io(ack_in, ack_n);
    end
  endtask
  // spi frame, bit31 (msb) first; clock parks at cpol between frames
  task automatic spi_frame(input cpol, input [31:0] v, input integer n, output [31:0] q);
    integer i;
    begin
      q = 32'h0;
      o_scl <= cpol;
      tick(8);
      o_chip_select_n <= 1'b0;
      tick(6);
      for (i = 0; i < n; i = i + 1) begin
        o_scl <= 1'b0;
        o_sda_low <= ~v[31-i];
        tick(4);
        o_scl <= 1'b1;
        tick(2);
        q[31-i] = i_sdo_line;
        tick(2);
      end
      o_scl <= cpol;
      tick(4);
      o_chip_select_n <= 1'b1;
      o_sda_low <= 1'b0;
      tick(8);
    end
  endtask
endmodule

// >>> dpssp_port.v
// dual protocol serial slave port with write fifo
`timescale 1ns/1ps
`include "dpssp_defs.vh"

// write fifo with registered output stage
module dpssp_fifo #(
  parameter W  = 16,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // fill side
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output wire         o_in_ready,
  // drain side
  output reg          o_out_valid,
  output reg  [W-1:0] o_out_data,
  input  wire         i_out_ready
);
  reg [W-1:0] mem [0:D-1];   // storage words
  reg [AW-1:0] wp_q;         // write pointer
  reg [AW-1:0] rp_q;         // read pointer
  reg [AW:0]   cnt_q;        // words held in storage
  wire         wr;           // accepted push
  wire         rd;           // move into output stage

  assign o_in_ready = (cnt_q < D);
  assign wr = i_in_valid & o_in_ready;
  assign rd = (~o_out_valid | i_out_ready) & (cnt_q != {(AW+1){1'b0}});

  // storage write, no reset needed on data
  always @(posedge i_clk) begin
    if (wr) begin
      mem[wp_q] <= i_in_data;
    end
  end

  // pointers, count and output stage
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_q        <= {AW{1'b0}};
      rp_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {W{1'b0}};
    end else begin
      if (wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd) begin
        rp_q        <= rp_q + 1'b1;
        o_out_data  <= mem[rp_q];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;   // drained, nothing behind it
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end
  end
endmodule

// primary host port: i2c or 4-wire spi slave
module dpssp_port #(
  parameter FIFO_DEPTH = `DPSSP_FIFO_DEPTH,
  parameter FIFO_AW    = `DPSSP_FIFO_AW
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_sys_rst,
  // primary pins
  input  wire       i_chip_select_n,
  input  wire       i_scl,
  output reg        o_scl_oe,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  input  wire       i_spi_out_address_strap,
  output reg        o_spi_out_address_strap,
  output reg        o_spi_out_address_strap_oe,
  // auxiliary bus pins
  input  wire       i_passthru,
  input  wire       i_aux_bus_clock_pin,
  output reg        o_aux_bus_clock_pin,
  output reg        o_aux_bus_clock_pin_oe,
  input  wire       i_aux_bus_data_pin,
  output reg        o_aux_bus_data_pin,
  output reg        o_aux_bus_data_pin_oe,
  output reg        o_aux_ctrl_en,
  // register file side
  output reg  [7:0] o_rd_addr,
  input  wire [7:0] i_rd_data,
  output wire       o_wr_valid,
  output wire [7:0] o_wr_addr,
  output wire [7:0] o_wr_data,
  input  wire       i_wr_ready,
  // status
  output reg        o_spi_mode,
  output reg        o_overrun
);
  // i2c states
  localparam [3:0] I_IDLE = 4'h0, I_ADDR = 4'h1, I_AACK = 4'h2, I_PTR  = 4'h3;
  localparam [3:0] I_PACK = 4'h4, I_WR   = 4'h5, I_WACK = 4'h6, I_RD   = 4'h7;
  localparam [3:0] I_HOST_ACKNOWLEDGE = 4'h8;

  // synchronisers: first stage feeds only second
  reg cs_s1, cs_s2, cs_p;
  reg scl_s1, scl_s2, scl_p;
  reg sda_s1, sda_s2, sda_p;
  reg str_s1, str_s2;
  reg asc_s1, asc_s2, asd_s1, asd_s2;

  // edge events from second stages
  wire scl_rise = scl_s2 & ~scl_p;
  wire scl_fall = ~scl_s2 & scl_p;
  wire i_start  = scl_s2 & scl_p & ~sda_s2 & sda_p;
  wire i_stop   = scl_s2 & scl_p & sda_s2 & ~sda_p;
  wire cs_fall  = ~cs_s2 & cs_p;

  reg        strap_q;      // address strap caught after reset
  reg        strap_done_q; // strap taken
  reg  [1:0] strap_wait_q; // edges until strap synchroniser is filled
  reg  [1:0] sda_hist_q;   // own primary data pull, last two cycles
  reg  [1:0] asd_hist_q;   // own aux data pull, last two cycles
  reg        cpol_q;       // clock idle level at select fall
  reg  [3:0] ist_q;        // i2c state
  reg  [3:0] ibit_q;       // i2c bit count
  reg  [7:0] ish_q;        // i2c shift register
  reg        irw_q;        // i2c direction
  reg  [7:0] ptr_q;        // i2c register pointer
  reg        i_drv_q;      // own i2c data drive
  reg  [3:0] sbit_q;       // spi bit position in frame
  reg        srw_q;        // spi direction
  reg  [6:0] saddr_q;      // spi register address
  reg  [7:0] srx_q;        // spi receive shift
  reg  [7:0] stx_q;        // spi transmit shift
  reg        wv_q;         // pending push to fifo
  reg [15:0] wd_q;         // pending address and data
  wire       f_rdy;        // fifo can take a word
  wire [15:0] f_out;       // fifo head word
  wire [6:0] my_addr = {`DPSSP_I2C_ADDR_HI, strap_q};

  // two-flop synchronisers and edge history
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {cs_s1, cs_s2, cs_p}    <= 3'h7;
      {scl_s1, scl_s2, scl_p} <= 3'h7;
      {sda_s1, sda_s2, sda_p} <= 3'h7;
      {str_s1, str_s2}        <= 2'h0;
      {asc_s1, asc_s2}        <= 2'h3;
      {asd_s1, asd_s2}        <= 2'h3;
    end else begin
      {cs_s1, cs_s2, cs_p}    <= {i_chip_select_n, cs_s1, cs_s2};
      {scl_s1, scl_s2, scl_p} <= {i_scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_p} <= {i_sda, sda_s1, sda_s2};
      {str_s1, str_s2}        <= {i_spi_out_address_strap, str_s1};
      {asc_s1, asc_s2}        <= {i_aux_bus_clock_pin, asc_s1};
      {asd_s1, asd_s2}        <= {i_aux_bus_data_pin, asd_s1};
    end
  end

  // mode select and strap capture
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_spi_mode   <= 1'b0;   // i2c after power-up
      cpol_q       <= 1'b0;
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else begin
      // strap read once, only after its synchroniser holds the pin level;
      // spi cannot drive that pin this early
      if (!strap_done_q) begin
        if (strap_wait_q == `DPSSP_STRAP_WAIT) begin
          strap_q      <= str_s2;
          strap_done_q <= 1'b1;
        end else begin
          strap_wait_q <= strap_wait_q + 2'h1;
        end
      end
      if (cs_fall) begin
        o_spi_mode <= 1'b1;   // never returns to i2c
        cpol_q     <= scl_s2; // idle level gives 00 or 11
      end
    end
  end

  // i2c slave engine; sync delay of 3 cycles fits fast-mode phases
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ist_q   <= I_IDLE;
      ibit_q  <= 4'h0;
      ish_q   <= 8'h00;
      irw_q   <= 1'b0;
      ptr_q   <= 8'h00;
      i_drv_q <= 1'b0;
    end else if (o_spi_mode) begin
      ist_q   <= I_IDLE;      // data pin now spi input
      i_drv_q <= 1'b0;
    end else if (i_start) begin
      ist_q   <= I_ADDR;      // start or repeated start
      ibit_q  <= 4'h0;
      i_drv_q <= 1'b0;
    end else if (i_stop) begin
      ist_q   <= I_IDLE;      // stop ends any length
      i_drv_q <= 1'b0;
    end else if (scl_rise) begin
      case (ist_q)
        I_ADDR, I_PTR, I_WR: begin
          ish_q  <= {ish_q[6:0], sda_s2}; // msb first
          ibit_q <= ibit_q + 4'h1;
        end
        I_RD: begin
          ibit_q <= ibit_q + 4'h1;
        end
        I_HOST_ACKNOWLEDGE: begin
          if (sda_s2) begin
            ist_q <= I_IDLE;          // host nack ends read
          end else begin
            ptr_q <= ptr_q + 8'h01;   // next byte, next register
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (ist_q)
        I_ADDR: begin
          if (ibit_q == `DPSSP_BYTE_BITS) begin
            if (ish_q[7:1] == my_addr) begin
              i_drv_q <= 1'b1;        // ack our address
              irw_q   <= ish_q[0];
              ist_q   <= I_AACK;
            end else begin
              ist_q <= I_IDLE;        // other target, stay silent
            end
          end
        end
        I_AACK: begin
          ibit_q <= 4'h0;
          if (irw_q) begin
            ish_q   <= {i_rd_data[6:0], 1'b0};
            i_drv_q <= ~i_rd_data[7]; // first bit of read byte
            ist_q   <= I_RD;
          end else begin
            i_drv_q <= 1'b0;
            ist_q   <= I_PTR;
          end
        end
        I_PTR: begin
          if (ibit_q == `DPSSP_BYTE_BITS) begin
            ptr_q   <= ish_q;         // pointer byte taken
            i_drv_q <= 1'b1;
            ist_q   <= I_PACK;
          end
        end
        I_WR: begin
          if (ibit_q == `DPSSP_BYTE_BITS) begin
            i_drv_q <= 1'b1;          // every data byte acked
            ist_q   <= I_WACK;
          end
        end
        I_PACK, I_WACK: begin
          if (ist_q == I_WACK) begin
            ptr_q <= ptr_q + 8'h01;
          end
          i_drv_q <= 1'b0;            // release after ack clock
          ibit_q  <= 4'h0;
          ist_q   <= I_WR;
        end
        I_RD: begin
          if (ibit_q == `DPSSP_BYTE_BITS) begin
            i_drv_q <= 1'b0;          // host owns the ack bit
            ist_q   <= I_HOST_ACKNOWLEDGE;
          end else begin
            i_drv_q <= ~ish_q[7];
            ish_q   <= {ish_q[6:0], 1'b0};
          end
        end
        I_HOST_ACKNOWLEDGE: begin
          ibit_q  <= 4'h0;
          ish_q   <= {i_rd_data[6:0], 1'b0};
          i_drv_q <= ~i_rd_data[7];
          ist_q   <= I_RD;
        end
        default: begin
          i_drv_q <= 1'b0;
        end
      endcase
    end
  end

  // spi engine, four-wire only: input on data pin, output on strap pin
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sbit_q  <= 4'h0;
      srw_q   <= 1'b0;
      saddr_q <= 7'h00;
      srx_q   <= 8'h00;
      stx_q   <= 8'h00;
      o_spi_out_address_strap <= 1'b0;
    end else if (cs_s2 | ~o_spi_mode) begin
      sbit_q <= `DPSSP_SPI_BIT_RW; // new frame at each select
    end else if (scl_rise) begin
      // both modes sample on the rising edge
      if (sbit_q == `DPSSP_SPI_BIT_RW) begin
        srw_q <= sda_s2;
      end else if (sbit_q < `DPSSP_SPI_BIT_D0) begin
        saddr_q <= {saddr_q[5:0], sda_s2};
      end else begin
        srx_q <= {srx_q[6:0], sda_s2};
      end
      if (sbit_q == `DPSSP_SPI_BIT_D7) begin
        sbit_q  <= `DPSSP_SPI_BIT_D0;       // burst: data bytes only
        saddr_q <= saddr_q + 7'h01;
      end else begin
        sbit_q <= sbit_q + 4'h1;
      end
    end else if (scl_fall & srw_q & (sbit_q >= `DPSSP_SPI_BIT_D0)) begin
      // output changes on the falling edge
      if (sbit_q == `DPSSP_SPI_BIT_D0) begin
        o_spi_out_address_strap <= i_rd_data[7];
        stx_q <= {i_rd_data[6:0], 1'b0};
      end else begin
        o_spi_out_address_strap <= stx_q[7];
        stx_q <= {stx_q[6:0], 1'b0};
      end
    end
  end

  // push of written bytes; spi cannot be stalled so overflow is flagged
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wv_q      <= 1'b0;
      wd_q      <= 16'h0000;
      o_overrun <= 1'b0;
    end else begin
      if (wv_q & f_rdy) begin
        wv_q <= 1'b0;
      end
      if (~o_spi_mode & scl_fall & (ist_q == I_WR) & (ibit_q == `DPSSP_BYTE_BITS)) begin
        wv_q <= 1'b1;
        wd_q <= {ptr_q, ish_q};
      end else if (o_spi_mode & ~cs_s2 & scl_rise & ~srw_q
                   & (sbit_q == `DPSSP_SPI_BIT_D7)) begin
        wv_q <= 1'b1;                       // one write per data byte
        wd_q <= {1'b0, saddr_q, srx_q[6:0], sda_s2};
        if (wv_q & ~f_rdy) begin
          o_overrun <= 1'b1;                // older byte lost
        end
      end
    end
  end

  // pin drivers, read address and pass-through switches
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sda_out  <= 1'b0;
      o_sda_oe   <= 1'b0;
      o_scl_oe   <= 1'b0;
      o_rd_addr  <= 8'h00;
      o_spi_out_address_strap_oe <= 1'b0;
      o_aux_bus_clock_pin        <= 1'b0;
      o_aux_bus_clock_pin_oe     <= 1'b0;
      o_aux_bus_data_pin         <= 1'b0;
      o_aux_bus_data_pin_oe      <= 1'b0;
      o_aux_ctrl_en              <= 1'b1;
      sda_hist_q                 <= 2'h0;
      asd_hist_q                 <= 2'h0;
    end else begin
      // remember own pulls while their echo is still in the synchroniser
      sda_hist_q <= {sda_hist_q[0], o_sda_oe};
      asd_hist_q <= {asd_hist_q[0], o_aux_bus_data_pin_oe};
      o_spi_out_address_strap_oe <= o_spi_mode & ~cs_s2;
      o_rd_addr <= o_spi_mode ? {1'b0, saddr_q} : ptr_q;
      // hold clock low while a byte waits for fifo room
      o_scl_oe  <= ~o_spi_mode & wv_q & ~f_rdy;
      // open drain: aux low is copied unless we caused it
      // a released low still shows for two cycles through the synchroniser;
      // without the hold-off both sides would pass it back and forth forever
      o_sda_oe  <= ~o_spi_mode & (i_drv_q |
                   (i_passthru & ~asd_s2 & ~o_aux_bus_data_pin_oe & ~(|asd_hist_q)));
      o_aux_ctrl_en          <= ~i_passthru;
      o_aux_bus_clock_pin_oe <= i_passthru & ~o_spi_mode & ~scl_s2;
      o_aux_bus_data_pin_oe  <= i_passthru & ~o_spi_mode & ~sda_s2 & ~o_sda_oe
                                & ~(|sda_hist_q);
    end
  end

  // write fifo between serial side and register file
  dpssp_fifo #(
    .W  (16),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (wv_q),
    .i_in_data   (wd_q),
    .o_in_ready  (f_rdy),
    .o_out_valid (o_wr_valid),
    .o_out_data  (f_out),
    .i_out_ready (i_wr_ready)
  );

  assign o_wr_addr = f_out[15:8];
  assign o_wr_data = f_out[7:0];
endmodule

// >>> dpssp_port_asserts.sv
// pin-level checks for the serial slave port
`timescale 1ns/1ps
module dpssp_port_asserts (
  // clock and reset
  input wire       i_clk,
  input wire       i_sys_rst,
  // watched pins
  input wire       i_chip_select_n,
  input wire       i_scl,
  input wire       i_passthru,
  input wire       i_wr_ready,
  input wire       o_sda_oe,
  input wire       o_scl_oe,
  input wire       o_spi_out_address_strap_oe,
  input wire       o_aux_bus_clock_pin_oe,
  input wire       o_aux_ctrl_en,
  input wire       o_wr_valid,
  input wire [7:0] o_wr_addr,
  input wire [7:0] o_wr_data,
  input wire       o_spi_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // spi once entered stays until reset
  property p_spi_sticky; o_spi_mode |=> o_spi_mode; endproperty
  a_spi_sticky: assert property (p_spi_sticky) else $error("spi mode dropped");
  // out line idle while not selected
  property p_sdo_idle; i_chip_select_n [*4] |-> !o_spi_out_address_strap_oe; endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("out line driven unselected");
  // shared data pin is input only in spi
  property p_sda_spi; o_spi_mode [*2] |-> !o_sda_oe; endproperty
  a_sda_spi: assert property (p_sda_spi) else $error("data pin driven in spi");
  // own aux controller off one cycle after pass-through
  property p_aux_ctrl; 1'b1 |=> o_aux_ctrl_en == !$past(i_passthru); endproperty
  a_aux_ctrl: assert property (p_aux_ctrl) else $error("aux control wrong");
  // primary clock low reaches the aux pin
  property p_aux_scl; (i_passthru && !i_scl) [*5] |-> o_aux_bus_clock_pin_oe; endproperty
  a_aux_scl: assert property (p_aux_scl) else $error("aux clock not linked");
  // stalled word must not move
  property p_wr_hold;
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled word changed");
  // stretching only in i2c with a word waiting
  property p_stretch; o_scl_oe |-> o_wr_valid && !o_spi_mode; endproperty
  a_stretch: assert property (p_stretch) else $error("stretch without full fifo");
  // data drive never changes while the clock is high, outside pass-through
  property p_ack_held; !i_passthru && i_scl && $past(i_scl) |-> $stable(o_sda_oe); endproperty
  a_ack_held: assert property (p_ack_held) else $error("data moved in high phase");
  c_stretch: cover property (o_scl_oe);
  c_spi_word: cover property (o_spi_mode && o_wr_valid);
  c_pass: cover property (i_passthru && o_aux_bus_clock_pin_oe);
endmodule
bind dpssp_port dpssp_port_asserts i_chk (
  .i_clk                      (i_clk),
  .i_sys_rst                  (i_sys_rst),
  .i_chip_select_n            (i_chip_select_n),
  .i_scl                      (i_scl),
  .i_passthru                 (i_passthru),
  .i_wr_ready                 (i_wr_ready),
  .o_sda_oe                   (o_sda_oe),
  .o_scl_oe                   (o_scl_oe),
  .o_spi_out_address_strap_oe (o_spi_out_address_strap_oe),
  .o_aux_bus_clock_pin_oe     (o_aux_bus_clock_pin_oe),
  .o_aux_ctrl_en              (o_aux_ctrl_en),
  .o_wr_valid                 (o_wr_valid),
  .o_wr_addr                  (o_wr_addr),
  .o_wr_data                  (o_wr_data),
  .o_spi_mode                 (o_spi_mode)
);

// >>> dpssp_port_bench.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ps
module dpssp_port_bench;
  // clock, reset and bench-driven inputs
  reg        i_clk;
  reg        i_sys_rst;
  reg        i_passthru;
  reg        i_wr_ready;
  reg        aux_sda_in;
  reg        seen_stretch;
  reg        strap_pull;
  // design outputs
  wire       o_scl_oe, o_sda_out, o_sda_oe, o_spi_out_address_strap;
  wire       o_spi_out_address_strap_oe, o_aux_bus_clock_pin, o_aux_bus_clock_pin_oe;
  wire       o_aux_bus_data_pin, o_aux_bus_data_pin_oe, o_aux_ctrl_en;
  wire       o_wr_valid, o_spi_mode, o_overrun;
  wire [7:0] o_rd_addr, o_wr_addr, o_wr_data;
  // lines with pull-ups; strap resistor level set by strap_pull
  wire       h_scl, h_sda_low, i_chip_select_n;
  wire       i_scl = h_scl & ~o_scl_oe;
  wire       i_sda = ~(h_sda_low | o_sda_oe);
  wire       i_spi_out_address_strap = o_spi_out_address_strap_oe ? o_spi_out_address_strap
                                                                  : strap_pull;
  wire       i_aux_bus_clock_pin = ~o_aux_bus_clock_pin_oe;
  wire       i_aux_bus_data_pin = aux_sda_in & ~o_aux_bus_data_pin_oe;
  // register file stand-in: data derived from address
  wire [7:0] i_rd_data = o_rd_addr ^ 8'h5a;
  reg [15:0] got_q [$];
  integer    errors, comparisons, cycles;

  dpssp_port i_dut (
    .i_clk                      (i_clk),
    .i_sys_rst                  (i_sys_rst),
    .i_chip_select_n            (i_chip_select_n),
    .i_scl                      (i_scl),
    .o_scl_oe                   (o_scl_oe),
    .i_sda                      (i_sda),
    .o_sda_out                  (o_sda_out),
    .o_sda_oe                   (o_sda_oe),
    .i_spi_out_address_strap    (i_spi_out_address_strap),
    .o_spi_out_address_strap    (o_spi_out_address_strap),
    .o_spi_out_address_strap_oe (o_spi_out_address_strap_oe),
    .i_passthru                 (i_passthru),
    .i_aux_bus_clock_pin        (i_aux_bus_clock_pin),
    .o_aux_bus_clock_pin        (o_aux_bus_clock_pin),
    .o_aux_bus_clock_pin_oe     (o_aux_bus_clock_pin_oe),
    .i_aux_bus_data_pin         (i_aux_bus_data_pin),
    .o_aux_bus_data_pin         (o_aux_bus_data_pin),
    .o_aux_bus_data_pin_oe      (o_aux_bus_data_pin_oe),
    .o_aux_ctrl_en              (o_aux_ctrl_en),
    .o_rd_addr                  (o_rd_addr),
    .i_rd_data                  (i_rd_data),
    .o_wr_valid                 (o_wr_valid),
    .o_wr_addr                  (o_wr_addr),
    .o_wr_data                  (o_wr_data),
    .i_wr_ready                 (i_wr_ready),
    .o_spi_mode                 (o_spi_mode),
    .o_overrun                  (o_overrun)
  );
  dpssp_host h (
    .i_clk          (i_clk),
    .i_sda_line     (i_sda),
    .i_scl_line     (i_scl),
    .i_sdo_line     (i_spi_out_address_strap),
    .o_scl          (h_scl),
    .o_sda_low      (h_sda_low),
    .o_chip_select_n(i_chip_select_n)
  );
  // 50 ns clock
  always #25 i_clk = ~i_clk;
  // collect drained words, watch stretching, cut hangs
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (o_scl_oe === 1'b1)
      seen_stretch = 1'b1;
    if (o_wr_valid === 1'b1 && i_wr_ready)
      got_q.push_back({o_wr_addr, o_wr_data});
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  function [15:0] pop_word();
    pop_word = got_q.size() ? got_q.pop_front() : 16'hxxxx;
  endfunction
  // burst write across pointer wrap with drain stalled until the fifo refuses
  task t_i2c_wr;
    reg [7:0] q;
    reg a;
    integer i;
    begin
      i_wr_ready <= 1'b0;
      fork
        begin
          repeat (2500) @(posedge i_clk);
          i_wr_ready <= 1'b1;
        end
      join_none
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hd8, 1'b1, q, a);
      chk("address ack", 0, a);
      h.i2c_byte(8'hf8, 1'b1, q, a);
      chk("pointer ack", 0, a);
      for (i = 0; i < 20; i = i + 1) begin
        h.i2c_byte(8'h30 + i[7:0], 1'b1, q, a);
        chk("data ack", 0, a);
      end
      h.i2c_cond(1'b0);
      h.tick(40);
      chk("stretch seen", 1, seen_stretch);
      for (i = 0; i < 20; i = i + 1)
        chk("i2c word", {8'hf8 + i[7:0], 8'h30 + i[7:0]}, pop_word());
      chk("fifo empty", 0, o_wr_valid);
      $display("test i2c write done");
    end
  endtask
  // foreign address ignored, then pointer, repeated start and burst read
  task t_i2c_rd;
    reg [7:0] q;
    reg a;
    integer i;
    begin
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hda, 1'b1, q, a);
      chk("foreign address", 1, a);
      h.i2c_cond(1'b0);
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hd8, 1'b1, q, a);
      h.i2c_byte(8'h40, 1'b1, q, a);
      chk("pointer ack", 0, a);
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hd9, 1'b1, q, a);
      chk("read address ack", 0, a);
      for (i = 0; i < 3; i = i + 1) begin
        h.i2c_byte(8'hff, i == 2, q, a);
        chk("read byte", {8'h00, (8'h40 + i[7:0]) ^ 8'h5a}, {8'h00, q});
      end
      h.i2c_cond(1'b0);
      chk("no stray word", 0, got_q.size());
      $display("test i2c read done");
    end
  endtask
  // strap pulled up, reset in mid-run, then the second address
  task t_strap;
    reg [7:0] q;
    reg a;
    begin
      strap_pull <= 1'b1;
      i_sys_rst <= 1'b1;
      h.tick(2);
      i_sys_rst <= 1'b0;
      h.tick(6);
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hd8, 1'b1, q, a);
      chk("low strap address", 1, a);
      h.i2c_cond(1'b0);
      h.i2c_cond(1'b1);
      h.i2c_byte(8'hda, 1'b1, q, a);
      chk("strap address ack", 0, a);
      h.i2c_byte(8'h10, 1'b1, q, a);
      h.i2c_byte(8'h77, 1'b1, q, a);
      chk("strap data ack", 0, a);
      h.i2c_cond(1'b0);
      h.tick(10);
      chk("strap word", 16'h1077, pop_word());
      $display("test strap done");
    end
  endtask
  // pass-through links both buses, own controller off
  task t_pass;
    reg bounce;
    begin
      i_passthru <= 1'b1;
      h.i2c_cond(1'b1);
      h.tick(4);
      chk("aux control", 0, o_aux_ctrl_en);
      chk("aux clock low", 1, o_aux_bus_clock_pin_oe);
      chk("aux data low", 1, o_aux_bus_data_pin_oe);
      h.i2c_cond(1'b0);
      aux_sda_in <= 1'b0;
      h.tick(6);
      chk("aux to host data", 1, o_sda_oe);
      aux_sda_in <= 1'b1;
      bounce = 1'b0;
      h.tick(4);
      repeat (10) begin
        h.tick(1);
        if (o_sda_oe !== 1'b0 || o_aux_bus_data_pin_oe !== 1'b0)
          bounce = 1'b1;
      end
      chk("no data bounce", 0, bounce);
      chk("open drain values", 0, {o_sda_out, o_aux_bus_clock_pin, o_aux_bus_data_pin});
      i_passthru <= 1'b0;
      h.tick(3);
      chk("aux control back", 1, o_aux_ctrl_en);
      chk("still i2c", 0, o_spi_mode);
      $display("test pass-through done");
    end
  endtask
  // mode 11 burst write over the 7-bit wrap, then mode 00 burst read
  task t_spi;
    reg [31:0] q;
    begin
      h.spi_frame(1'b1, {1'b0, 7'h7f, 8'h3c, 8'h3d, 8'h00}, 24, q);
      chk("spi mode", 1, o_spi_mode);
      chk("spi word", {8'h7f, 8'h3c}, pop_word());
      chk("spi burst word", {8'h00, 8'h3d}, pop_word());
      h.spi_frame(1'b0, {1'b1, 7'h21, 24'h0}, 24, q);
      chk("spi read", 16'h7b78, q[23:8]);
      chk("overrun", 0, o_overrun);
      $display("test spi done");
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // reset, then scenarios; spi last since it locks for good
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_passthru = 1'b0;
    i_wr_ready = 1'b1;
    aux_sda_in = 1'b1;
    seen_stretch = 1'b0;
    strap_pull = 1'b0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    h.tick(6);
    t_i2c_wr;
    t_i2c_rd;
    t_strap;
    t_pass;
    t_spi;
    finish_test;
  end
endmodule
